/* test/ctm_asserts.sv */
// checker: timing and field checks on the monitor read port
`timescale 1ns/1ps
`default_nettype none
module ctm_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // settings and port
  input wire logic auto_set_active,
  input wire ctm_pkg::ctm_setting_t auto_setting,
  input wire ctm_pkg::ctm_setting_t programmed_setting,
  input wire ctm_pkg::ctm_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  import ctm_pkg::*;
  ctm_setting_t s;
  assign s = auto_set_active ? auto_setting : programmed_setting;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_read_one_pulse: assert property (
    rvalid == ($past(req.rd) && !$past(rst))) else $error("bad rvalid");
  a_write_no_answer: assert property (
    req.wr && !req.rd |=> !rvalid) else $error("write answered");
  a_r_factor_val: assert property (
    rvalid && $past(req.addr) == 8'h64 |->
    rdata[3:0] == $past(s.pll_r_factor, 2)) else $error("bad r");
  a_dsp_div_val: assert property (
    rvalid && $past(req.addr) == 8'h65 |->
    rdata[6:0] == $past(s.dsp_divide, 2)) else $error("bad dsp");
  a_dac_div_val: assert property (
    rvalid && $past(req.addr) == 8'h66 |->
    rdata[6:0] == $past(s.dac_divide, 2)) else $error("bad dac");
  a_pump_div_val: assert property (
    rvalid && $past(req.addr) == 8'h67 |->
    rdata[6:0] == $past(s.pump_divide, 2)) else $error("bad pump");
  a_os_div_val: assert property (
    rvalid && $past(req.addr) == 8'h68 |->
    rdata[6:0] == $past(s.oversample_divide, 2)) else $error("bad os");
  a_pll_run_bit: assert property (
    rvalid && $past(req.addr) == 8'h69 |->
    rdata[4] == $past(s.pll_running, 2)) else $error("bad run");
  a_pll_src_val: assert property (
    rvalid && $past(req.addr) == 8'h69 |->
    rdata[2:0] == $past(s.pll_source, 2)) else $error("bad src");
endmodule
bind ctm_monitor_regs ctm_asserts u_chk (.clock(clock), .rst(rst),
  .auto_set_active(auto_set_active), .auto_setting(auto_setting),
  .programmed_setting(programmed_setting), .req(req), .rdata(rdata),
  .rvalid(rvalid));
`default_nettype wire

/* test/tb_top.sv */
// testbench: monitor register reads, selection and write masking
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ctm_pkg::*;
  logic clock = 0;
  logic rst = 1;
  logic auto_set_active = 0;
  ctm_setting_t auto_setting = '0;
  ctm_setting_t programmed_setting = '0;
  ctm_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  int n_errors = 0;
  int compares = 0;
  ctm_monitor_regs dut (.clock(clock), .rst(rst),
    .auto_set_active(auto_set_active), .auto_setting(auto_setting),
    .programmed_setting(programmed_setting), .req(req), .rdata(rdata),
    .rvalid(rvalid));
  initial forever #25 clock = ~clock;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    repeat (2) @(posedge clock);
    req <= '{1'b1, 1'b0, ad, 8'h00};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clock);
    req <= '{1'b0, 1'b1, ad, d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic s_auto;
    auto_setting <= '{4'hF, 7'h7F, 7'h00, 7'h01, 7'h55, 1'b1, 3'h3};
    programmed_setting <= '{4'h2, 7'h11, 7'h22, 7'h33, 7'h44, 1'b0, 3'h1};
    auto_set_active <= 1'b1;
    rd(8'h64, 8'h0F);
    rd(8'h65, 8'h7F);
    rd(8'h66, 8'h00);
    rd(8'h67, 8'h01);
    rd(8'h68, 8'h55);
    rd(8'h69, 8'h13);
    @(posedge clock);
    auto_set_active <= 1'b0;
    rd(8'h64, 8'h02);
    rd(8'h68, 8'h44);
  endtask
  task automatic s_src;
    for (int c = 3; c >= 0; c--) begin
      @(posedge clock);
      programmed_setting.pll_source <= c[2:0];
      programmed_setting.pll_running <= c[0];
      rd(8'h69, {3'h0, c[0], 1'b0, c[2:0]});
    end
  endtask
  task automatic s_wr;
    wr(8'h65, 8'h80);
    wr(8'h64, 8'hFF);
    wr(8'h69, 8'hFF);
    wr(8'h6A, 8'hFF);
    rd(8'h65, 8'h91);
    rd(8'h64, 8'hF2);
    rd(8'h69, 8'hE8);
    rd(8'h6A, 8'h00);
  endtask
  task automatic s_rst;
    wr(8'h66, 8'hFF);
    wr(8'h67, 8'h80);
    wr(8'h68, 8'hFF);
    rd(8'h66, 8'hA2);
    rd(8'h67, 8'hB3);
    rd(8'h68, 8'hC4);
    @(posedge clock);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    rd(8'h66, 8'h22);
    rd(8'h64, 8'h02);
    rd(8'h69, 8'h00);
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    s_auto();
    s_src();
    s_wr();
    s_rst();
    wrap_up();
  end
endmodule
`default_nettype wire

/* verilog/ctm_monitor_regs.sv */
// clock-tree monitor registers, read through the control port
`timescale 1ns/1ps
`default_nettype none
module ctm_monitor_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // clock generator settings
  input wire logic auto_set_active,
  input wire ctm_pkg::ctm_setting_t auto_setting,
  input wire ctm_pkg::ctm_setting_t programmed_setting,
  // control port
  input wire ctm_pkg::ctm_req_t req,
  output logic [7:0] rdata,
  output logic rvalid
);
  import ctm_pkg::*;

  // ----------------------------------------
  // register select lines, one per offset
  // ----------------------------------------
  localparam int SEL_R = 0;
  localparam int SEL_DSP = 1;
  localparam int SEL_DAC = 2;
  localparam int SEL_PUMP = 3;
  localparam int SEL_OSR = 4;
  localparam int SEL_STATE = 5;
  localparam int SEL_W = 6;

  // ----------------------------------------
  // setting in use
  // ----------------------------------------
  ctm_setting_t in_use;
  ctm_setting_t live;
  logic [7:0] rsvd_r;
  logic [7:0] rsvd_dsp;
  logic [7:0] rsvd_dac;
  logic [7:0] rsvd_pump;
  logic [7:0] rsvd_osr;
  logic [7:0] rsvd_state;
  logic [7:0] next_rdata;
  logic [SEL_W-1:0] wr_sel;
  logic [SEL_W-1:0] rd_sel;

  always_comb begin
    live = auto_set_active ? auto_setting : programmed_setting;
  end

  // one stage: a read sees the setting of the edge before it
  always_ff @(posedge clock) begin
    if (rst) begin
      in_use <= '0;
    end else begin
      in_use <= live;
    end
  end

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  // offset to one-hot select; unmapped offsets select nothing
  function automatic logic [SEL_W-1:0] decode_offset(
    input logic [7:0] offset);
    logic [SEL_W-1:0] sel;
    sel = '0;
    unique case (offset)
      ADDR_PLL_R_FACTOR_MONITOR: begin
        sel[SEL_R] = 1'h1;
      end
      ADDR_DSP_CLOCK_DIVIDER_MONITOR: begin
        sel[SEL_DSP] = 1'h1;
      end
      ADDR_DAC_CLOCK_DIVIDER_MONITOR: begin
        sel[SEL_DAC] = 1'h1;
      end
      ADDR_PUMP_CLOCK_DIVIDER_MONITOR: begin
        sel[SEL_PUMP] = 1'h1;
      end
      ADDR_OVERSAMPLE_DIVIDER_MONITOR: begin
        sel[SEL_OSR] = 1'h1;
      end
      ADDR_PLL_STATE_MONITOR: begin
        sel[SEL_STATE] = 1'h1;
      end
      default: begin
        sel = '0;
      end
    endcase
    return sel;
  endfunction

  // divider register byte: reserved bit over a ratio-minus-one code
  function automatic logic [7:0] divider_byte(input logic [7:0] rsvd,
    input logic [DIVIDE_W-1:0] code);
    return {rsvd[DIVIDE_W], code};
  endfunction

  // divider reserved bit as written; the ratio bits never store
  function automatic logic [7:0] divider_rsvd(input logic [7:0] wdata);
    return {wdata[DIVIDE_W], 7'h00};
  endfunction

  always_comb begin
    wr_sel = req.wr ? decode_offset(req.addr) : '0;
    rd_sel = decode_offset(req.addr);
  end

  // ----------------------------------------
  // reserved bits: the only writable storage
  // ----------------------------------------
  // monitor fields hold no state of their own, so writes land only here
  always_ff @(posedge clock) begin
    if (rst) begin
      rsvd_r <= RESERVED_RESET;
    end else if (wr_sel[SEL_R]) begin
      rsvd_r <= {req.wdata[7:R_FACTOR_W], 4'h0};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rsvd_dsp <= RESERVED_RESET;
    end else if (wr_sel[SEL_DSP]) begin
      rsvd_dsp <= divider_rsvd(req.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rsvd_dac <= RESERVED_RESET;
    end else if (wr_sel[SEL_DAC]) begin
      rsvd_dac <= divider_rsvd(req.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rsvd_pump <= RESERVED_RESET;
    end else if (wr_sel[SEL_PUMP]) begin
      rsvd_pump <= divider_rsvd(req.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rsvd_osr <= RESERVED_RESET;
    end else if (wr_sel[SEL_OSR]) begin
      rsvd_osr <= divider_rsvd(req.wdata);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rsvd_state <= RESERVED_RESET;
    end else if (wr_sel[SEL_STATE]) begin
      rsvd_state <= {req.wdata[7:PLL_RUNNING_BIT+1], 1'h0,
        req.wdata[STATE_RSVD_LO_BIT], 3'h0};
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    unique case (1'h1)
      rd_sel[SEL_R]: begin
        next_rdata = {rsvd_r[7:R_FACTOR_W], in_use.pll_r_factor};
      end
      rd_sel[SEL_DSP]: begin
        next_rdata = divider_byte(rsvd_dsp, in_use.dsp_divide);
      end
      rd_sel[SEL_DAC]: begin
        next_rdata = divider_byte(rsvd_dac, in_use.dac_divide);
      end
      rd_sel[SEL_PUMP]: begin
        next_rdata = divider_byte(rsvd_pump, in_use.pump_divide);
      end
      rd_sel[SEL_OSR]: begin
        next_rdata = divider_byte(rsvd_osr,
          in_use.oversample_divide);
      end
      rd_sel[SEL_STATE]: begin
        next_rdata = rsvd_state;
        next_rdata[PLL_RUNNING_BIT] = in_use.pll_running;
        next_rdata[SOURCE_W-1:0] = in_use.pll_source;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  // rdata holds between reads; rvalid marks the cycle after a read
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
      rvalid <= 1'h0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/ctm_pkg.sv */
// package: register map, field layout and types for the clock-tree monitor
`default_nettype none
package ctm_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_PLL_R_FACTOR_MONITOR = 8'h64;
  localparam logic [7:0] ADDR_DSP_CLOCK_DIVIDER_MONITOR = 8'h65;
  localparam logic [7:0] ADDR_DAC_CLOCK_DIVIDER_MONITOR = 8'h66;
  localparam logic [7:0] ADDR_PUMP_CLOCK_DIVIDER_MONITOR = 8'h67;
  localparam logic [7:0] ADDR_OVERSAMPLE_DIVIDER_MONITOR = 8'h68;
  localparam logic [7:0] ADDR_PLL_STATE_MONITOR = 8'h69;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int R_FACTOR_W = 4;
  localparam int DIVIDE_W = 7;
  localparam int SOURCE_W = 3;
  localparam int PLL_RUNNING_BIT = 4;
  localparam int STATE_RSVD_LO_BIT = 3;
  localparam logic [7:0] RESERVED_RESET = 8'h00;
  // ----------------------------------------
  // pll reference codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    CTM_SRC_MASTER_CLOCK = 3'h0,
    CTM_SRC_BIT_CLOCK = 3'h1,
    CTM_SRC_INTERNAL_OSCILLATOR = 3'h2,
    CTM_SRC_GPIO_PIN = 3'h3
  } ctm_source_t;
  // ----------------------------------------
  // one clock-tree setting: ratio-minus-one codes, the pll running flag and the pll source code
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] pll_r_factor;
    logic [6:0] dsp_divide;
    logic [6:0] dac_divide;
    logic [6:0] pump_divide;
    logic [6:0] oversample_divide;
    logic pll_running;
    logic [2:0] pll_source;
  } ctm_setting_t;
  // register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ctm_req_t;
endpackage
`default_nettype wire
